// >>> core/mas_pkg.sv
// Package: constants, types and register map of the multi-address I2C slave
package mas_pkg;

	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] MAS_REG_STATUS = 8'h00;
	localparam logic [7:0] MAS_REG_RXHOLD = 8'h04;
	localparam logic [7:0] MAS_REG_FLAGS  = 8'h08;
	localparam logic [7:0] MAS_REG_ACTION = 8'h0c;
	localparam logic [7:0] MAS_REG_ADRTBL = 8'h10;
	localparam logic [7:0] MAS_REG_ACKTBL = 8'h14;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int MAS_FLG_DONE_BIT  = 0;
	localparam int MAS_FLG_STOP_BIT  = 1;
	localparam int MAS_ACT_CODE_LSB  = 8;
	localparam int MAS_ACT_SRC_LSB   = 10;
	localparam int MAS_TBL_IDX_LSB   = 8;
	localparam int MAS_ST_TRC_BIT    = 3;
	localparam int MAS_ST_ACKD_BIT   = 2;
	localparam int MAS_ST_STD_BIT    = 1;
	localparam int MAS_ST_SPD_BIT    = 0;

	// ************************************************************
	// Table values and reset values
	// ************************************************************
	localparam logic [7:0] MAS_TBL_NONE    = 8'h00;
	localparam logic [7:0] MAS_ACK_YES     = 8'h0f;
	localparam logic [7:0] MAS_ACK_NO      = 8'h00;
	localparam logic [7:0] MAS_STATUS_RST  = 8'h00;
	localparam logic [3:0] MAS_ACK_GRP_MAX = 4'h4;
	localparam logic [3:0] MAS_BITS_BYTE   = 4'h8;
	localparam logic [3:0] MAS_SKIP_WRAP   = 4'h8;

	// ************************************************************
	// Restart actions and transmit sources
	// ************************************************************
	typedef enum logic [1:0] {
		MAS_ACT_NONE = 2'h0,
		MAS_ACT_RX   = 2'h1,
		MAS_ACT_TX   = 2'h2,
		MAS_ACT_END  = 2'h3
	} mas_act_e;

	typedef enum logic [1:0] {
		MAS_SRC_ARG  = 2'h0,
		MAS_SRC_MEM  = 2'h1,
		MAS_SRC_CONV = 2'h2
	} mas_src_e;

	// ************************************************************
	// Pin carriers
	// ************************************************************
	typedef struct packed {
		logic scl;
		logic sda;
	} mas_pin_in_s;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} mas_pin_out_s;

endpackage

// >>> core/mas_slave.sv
// Multi-address I2C slave with clock stall and restart actions
`timescale 1ns/1ps
`default_nettype none

module mas_slave
	import mas_pkg::*;
#(
	parameter logic [3:0] CONV_GROUP = 4'h1,
	parameter logic [3:0] MEM_GROUP  = 4'h2,
	parameter int         MEM_DEPTH  = 128
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset,
	input  wire mas_pin_in_s  i_pins,
	output var  mas_pin_out_s o_pins,
	input  wire logic [7:0]   i_addr,
	input  wire logic [31:0]  i_wdata,
	input  wire logic         i_wr,
	input  wire logic         i_rd,
	output logic [31:0]       o_rdata,
	output logic              o_byte_done,
	output logic              o_stop_seen,
	input  wire logic         i_conv_done,
	input  wire logic [47:0]  i_conv_avg
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (CONV_GROUP == 4'h0 || MEM_GROUP == 4'h0 || CONV_GROUP == MEM_GROUP) begin : g_bad_grp
		$error("Group codes must be nonzero and distinct");
	end
	if (MEM_DEPTH != 128) begin : g_bad_depth
		$error("Memory offset logic serves 128 bytes only");
	end

	// ************************************************************
	// Types and functions
	// ************************************************************
	typedef enum logic [7:0] {
		ST_IDLE  = 8'b0000_0001,
		ST_ADDR  = 8'b0000_0010,
		ST_AACK  = 8'b0000_0100,
		ST_RX    = 8'b0000_1000,
		ST_RXACK = 8'b0001_0000,
		ST_STALL = 8'b0010_0000,
		ST_TX    = 8'b0100_0000,
		ST_TXACK = 8'b1000_0000
	} mas_state_e;

	// Default address table entry for a 7-bit index
	function automatic logic [7:0] adr_default(input logic [6:0] idx);
		case (idx)
			7'h30:   adr_default = 8'h10;
			7'h38:   adr_default = 8'h20;
			7'h40:   adr_default = 8'h30;
			7'h48:   adr_default = 8'h40;
			default: adr_default = MAS_TBL_NONE;
		endcase
	endfunction

	// Conversion buffer byte: even = upper four bits, odd = lower eight
	function automatic logic [7:0] conv_byte(input logic [11:0] ch, input logic low);
		conv_byte = low ? ch[7:0] : {4'h0, ch[11:8]};
	endfunction

	// ************************************************************
	// Declarations
	// ************************************************************
	logic             scl_s1_r, scl_s2_r, scl_d_r;
	logic             sda_s1_r, sda_s2_r, sda_d_r;
	logic             scl_rise, scl_fall, sda_rise, sda_fall;
	logic             start_det, stop_det;
	mas_state_e       state_r;
	logic [3:0]       bitcnt_r;
	logic [3:0]       skipcnt_r;
	logic             skipping_r;
	logic [7:0]       shreg_r;
	logic [7:0]       rx_byte_hold_r;
	logic [7:0]       comm_status_r;
	logic             byte_done_flag_r;
	logic             stop_flag_r;
	mas_pin_out_s     drv_r;
	logic [6:0]       mem_off_r;
	logic             mem_first_r;
	logic [2:0]       conv_ptr_r;
	logic [7:0]       address_lookup_table [0:127];
	logic [7:0]       group_acknowledge_table [0:15];
	logic [7:0]       mem_r [0:MEM_DEPTH-1];
	logic [11:0]      conv_buf_r [0:3];
	logic [7:0]       lookup;
	logic             selected;
	logic             act_wr;
	mas_act_e         act_code;
	mas_src_e         act_src;
	logic [7:0]       tx_byte;
	logic             mem_wr;
	logic [31:0]      rdata_r;

	// ************************************************************
	// Pin synchronisers and bus conditions
	// ************************************************************
	// Two flops before use; third flop for edge finding and for the SCL-high check of start/stop
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end else begin
			scl_s1_r <= i_pins.scl;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= i_pins.sda;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	assign scl_rise  = scl_s2_r & ~scl_d_r;
	assign scl_fall  = ~scl_s2_r & scl_d_r;
	assign sda_rise  = sda_s2_r & ~sda_d_r;
	assign sda_fall  = ~sda_s2_r & sda_d_r;
	// SDA moving while SCL stays high marks start or stop
	assign start_det = sda_fall & scl_s2_r & scl_d_r;
	assign stop_det  = sda_rise & scl_s2_r & scl_d_r;

	// ************************************************************
	// Address decode and restart action decode
	// ************************************************************
	// upper seven bits index table
	assign lookup   = address_lookup_table[shreg_r[7:1]];
	assign selected = (lookup != MAS_TBL_NONE) &&
	                  (group_acknowledge_table[lookup[7:4]] == MAS_ACK_YES);
	assign act_code = mas_act_e'(i_wdata[MAS_ACT_CODE_LSB +: 2]);
	assign act_src  = mas_src_e'(i_wdata[MAS_ACT_SRC_LSB +: 2]);
	assign act_wr   = i_wr && (i_addr == MAS_REG_ACTION) && (state_r == ST_STALL);

	// Transmit byte source chosen by the action
	always_comb begin
		case (act_src)
			MAS_SRC_MEM:  tx_byte = mem_r[mem_off_r];
			MAS_SRC_CONV: tx_byte = conv_byte(conv_buf_r[conv_ptr_r[2:1]], conv_ptr_r[0]);
			default:      tx_byte = i_wdata[7:0];
		endcase
	end

	// bytes after the offset go to memory
	assign mem_wr = (state_r == ST_RXACK) && scl_fall && !stop_det && !start_det &&
	                (comm_status_r[7:4] == MEM_GROUP) && !mem_first_r;

	// ************************************************************
	// Protocol state machine
	// ************************************************************
	// Drives SDA/SCL enables, status, rx hold, done flag and pointers
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r          <= ST_IDLE;
			bitcnt_r         <= 4'h0;
			skipcnt_r        <= 4'h0;
			skipping_r       <= 1'b0;
			shreg_r          <= 8'h00;
			rx_byte_hold_r   <= 8'h00;
			comm_status_r    <= MAS_STATUS_RST;
			byte_done_flag_r <= 1'b0;
			drv_r            <= '0;
			mem_off_r        <= 7'h00;
			mem_first_r      <= 1'b0;
			conv_ptr_r       <= 3'h0;
		end else if (stop_det) begin
			// Stop ends the transfer; release both lines, done flag keeps its value
			state_r                        <= ST_IDLE;
			skipping_r                     <= 1'b0;
			drv_r.sda_oe                   <= 1'b0;
			drv_r.scl_oe                   <= 1'b0;
			comm_status_r[MAS_ST_SPD_BIT] <= 1'b1;
		end else if (start_det) begin
			// Start or repeated start begins address reception
			state_r       <= ST_ADDR;
			bitcnt_r      <= 4'h0;
			skipping_r    <= 1'b0;
			drv_r.sda_oe  <= 1'b0;
			drv_r.scl_oe  <= 1'b0;
			comm_status_r <= 8'h02;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (skipping_r && scl_rise) begin
						skipcnt_r <= (skipcnt_r == MAS_SKIP_WRAP) ? 4'h0 : skipcnt_r + 4'h1;
					end
				end
				ST_ADDR: begin
					if (scl_rise) begin
						shreg_r  <= {shreg_r[6:0], sda_s2_r};
						bitcnt_r <= bitcnt_r + 4'h1;
					end else if (scl_fall && bitcnt_r == MAS_BITS_BYTE) begin
						if (selected) begin
							comm_status_r[7:4]           <= lookup[7:4];
							comm_status_r[MAS_ST_TRC_BIT] <= shreg_r[0];
							drv_r.sda_oe                 <= 1'b1;
							state_r                      <= ST_AACK;
						end else begin
							skipping_r <= 1'b1;
							skipcnt_r  <= 4'h0;
							state_r    <= ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						drv_r.sda_oe <= 1'b0;
						bitcnt_r     <= 4'h0;
						comm_status_r[MAS_ST_ACKD_BIT] <= 1'b1;
						if (comm_status_r[MAS_ST_TRC_BIT]) begin
							drv_r.scl_oe     <= 1'b1;
							byte_done_flag_r <= 1'b1;
							state_r          <= ST_STALL;
							if (comm_status_r[7:4] == CONV_GROUP) begin
								conv_ptr_r <= 3'h0;
							end
						end else begin
							// first written byte is the offset
							mem_first_r <= 1'b1;
							state_r     <= ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_rise) begin
						shreg_r  <= {shreg_r[6:0], sda_s2_r};
						bitcnt_r <= bitcnt_r + 4'h1;
						if (bitcnt_r == MAS_BITS_BYTE - 4'h1) begin
							rx_byte_hold_r <= {shreg_r[6:0], sda_s2_r};
						end
					end else if (scl_fall && bitcnt_r == MAS_BITS_BYTE) begin
						drv_r.sda_oe <= 1'b1;
						state_r      <= ST_RXACK;
					end
				end
				ST_RXACK: begin
					if (scl_fall) begin
						drv_r.sda_oe     <= 1'b0;
						drv_r.scl_oe     <= 1'b1;
						byte_done_flag_r <= 1'b1;
						comm_status_r[MAS_ST_ACKD_BIT] <= 1'b1;
						state_r          <= ST_STALL;
						if (comm_status_r[7:4] == MEM_GROUP) begin
							mem_first_r <= 1'b0;
							mem_off_r   <= mem_first_r ? rx_byte_hold_r[6:0] : mem_off_r + 7'h01;
						end
					end
				end
				ST_STALL: begin
					if (act_wr) begin
						byte_done_flag_r <= 1'b0;
						bitcnt_r         <= 4'h0;
						drv_r.scl_oe     <= 1'b0;
						case (act_code)
							MAS_ACT_RX: begin
								state_r <= ST_RX;
							end
							MAS_ACT_TX: begin
								shreg_r      <= tx_byte;
								drv_r.sda_oe <= ~tx_byte[7];
								state_r      <= ST_TX;
								if (act_src == MAS_SRC_MEM) begin
									mem_off_r <= mem_off_r + 7'h01;
								end
								if (act_src == MAS_SRC_CONV) begin
									// wraps channel 3 low to 0 high
									conv_ptr_r <= conv_ptr_r + 3'h1;
								end
							end
							MAS_ACT_END: begin
								comm_status_r <= MAS_STATUS_RST;
								state_r       <= ST_IDLE;
							end
							default: begin
								// No action code: keep stalling
								drv_r.scl_oe     <= 1'b1;
								byte_done_flag_r <= 1'b1;
							end
						endcase
					end
				end
				ST_TX: begin
					if (scl_rise && bitcnt_r == 4'h0) begin
						comm_status_r[2:0] <= 3'b000;
					end
					if (scl_fall) begin
						if (bitcnt_r == MAS_BITS_BYTE - 4'h1) begin
							// Release SDA for the master's answer
							drv_r.sda_oe <= 1'b0;
							state_r      <= ST_TXACK;
						end else begin
							drv_r.sda_oe <= ~shreg_r[6];
							shreg_r      <= {shreg_r[6:0], 1'b0};
							bitcnt_r     <= bitcnt_r + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise) begin
						comm_status_r[MAS_ST_ACKD_BIT] <= ~sda_s2_r;
					end else if (scl_fall) begin
						drv_r.scl_oe     <= 1'b1;
						byte_done_flag_r <= 1'b1;
						state_r          <= ST_STALL;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Stop-detect flag
	// ************************************************************
	// Set wins over a clear in the same cycle
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			stop_flag_r <= 1'b0;
		end else if (stop_det) begin
			stop_flag_r <= 1'b1;
		end else if (i_wr && i_addr == MAS_REG_FLAGS && i_wdata[MAS_FLG_STOP_BIT]) begin
			stop_flag_r <= 1'b0;
		end
	end

	// ************************************************************
	// Lookup tables
	// ************************************************************
	// example mapping after reset
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < 128; i++) begin
				address_lookup_table[i] <= adr_default(7'(i));
			end
			for (int g = 0; g < 16; g++) begin
				group_acknowledge_table[g] <= (g != 0 && 4'(g) <= MAS_ACK_GRP_MAX) ?
				                              MAS_ACK_YES : MAS_ACK_NO;
			end
		end else if (i_wr && i_addr == MAS_REG_ADRTBL) begin
			address_lookup_table[i_wdata[MAS_TBL_IDX_LSB +: 7]] <= i_wdata[7:0];
		end else if (i_wr && i_addr == MAS_REG_ACKTBL) begin
			group_acknowledge_table[i_wdata[MAS_TBL_IDX_LSB +: 4]] <= i_wdata[7:0];
		end
	end

	// ************************************************************
	// Byte memory and conversion buffer
	// ************************************************************
	// No reset: plain storage array
	always_ff @(posedge i_sys_clk) begin
		if (mem_wr) begin
			mem_r[mem_off_r] <= rx_byte_hold_r;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int c = 0; c < 4; c++) begin
				conv_buf_r[c] <= 12'h000;
			end
		end else if (i_conv_done) begin
			for (int c = 0; c < 4; c++) begin
				conv_buf_r[c] <= i_conv_avg[c*12 +: 12];
			end
		end
	end

	// ************************************************************
	// Register read port
	// ************************************************************
	// Data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_r <= 32'h0000_0000;
		end else if (i_rd) begin
			case (i_addr)
				MAS_REG_STATUS: rdata_r <= {24'h00_0000, comm_status_r};
				MAS_REG_RXHOLD: rdata_r <= {24'h00_0000, rx_byte_hold_r};
				MAS_REG_FLAGS:  rdata_r <= {30'h0, stop_flag_r, byte_done_flag_r};
				default:        rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_pins      = drv_r;
	assign o_rdata     = rdata_r;
	assign o_byte_done = byte_done_flag_r;
	assign o_stop_seen = stop_flag_r;

endmodule // mas_slave

`default_nettype wire

// >>> tb/mas_slave_props.sv
// Checker: port-level properties of the multi-address I2C slave
`timescale 1ns/1ps
`default_nettype none

module mas_slave_props
	import mas_pkg::*;
(
	input wire logic         i_sys_clk,
	input wire logic         i_reset,
	input wire mas_pin_in_s  i_pins,
	input wire mas_pin_out_s o_pins,
	input wire logic [7:0]   i_addr,
	input wire logic [31:0]  i_wdata,
	input wire logic         i_wr,
	input wire logic         i_rd,
	input wire logic [31:0]  o_rdata,
	input wire logic         o_byte_done,
	input wire logic         o_stop_seen
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);

	// Accepted restart action, shared by the stall properties
	wire logic act_w = i_wr && i_addr == MAS_REG_ACTION &&
	                   i_wdata[MAS_ACT_CODE_LSB +: 2] != 2'h0;
	wire logic clr_w = i_wr && i_addr == MAS_REG_FLAGS && i_wdata[MAS_FLG_STOP_BIT];

	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data not zero outside a read answer");
	done_stall_a: assert property (o_byte_done |-> o_pins.scl_oe)
		else $error("done flag without clock stall");
	stall_rise_a: assert property ($rose(o_pins.scl_oe) |-> ##[0:1] o_byte_done)
		else $error("clock stall without done flag");
	stall_hold_a: assert property (o_pins.scl_oe && !act_w |=> o_pins.scl_oe)
		else $error("stall dropped without restart action");
	stall_free_a: assert property (o_byte_done && act_w |=> !o_pins.scl_oe && !o_byte_done)
		else $error("restart action did not release stall");
	stop_keep_a: assert property (o_stop_seen && !clr_w |=> o_stop_seen)
		else $error("stop flag fell without a clear");
	stop_set_a: assert property ($rose(i_pins.sda) && i_pins.scl |-> ##[1:6] o_stop_seen)
		else $error("stop condition not flagged");
	// Slave data may change only while SCL is low
	sda_still_a: assert property (i_pins.scl [*5] |-> $stable(o_pins.sda_oe))
		else $error("data line moved while clock high");
	od_low_a: assert property (!o_pins.scl_o && !o_pins.sda_o)
		else $error("open-drain pin driven high");
endmodule // mas_slave_props

bind mas_slave mas_slave_props u_props (
	.i_sys_clk  (i_sys_clk),
	.i_reset    (i_reset),
	.i_pins     (i_pins),
	.o_pins     (o_pins),
	.i_addr     (i_addr),
	.i_wdata    (i_wdata),
	.i_wr       (i_wr),
	.i_rd       (i_rd),
	.o_rdata    (o_rdata),
	.o_byte_done(o_byte_done),
	.o_stop_seen(o_stop_seen)
);
`default_nettype wire

// >>> tb/mas_i2c_master.sv
// Behavioural I2C bus master that honours clock stretching
`timescale 1ns/1ps
`default_nettype none

module mas_i2c_master (
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_scl_low,
	output logic      o_sda_low
);
	localparam realtime HALF = 62.5;

	// Bus idle high until a frame starts
	initial begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end

	// One clock pulse; waits while the slave stalls SCL
	task automatic bit_x(input logic b, output logic s);
		o_sda_low = !b;
		#HALF;
		o_scl_low = 1'b0;
		wait (i_scl === 1'b1);
		#HALF;
		s = i_sda;
		o_scl_low = 1'b1;
	endtask

	task automatic start();
		logic s;
		bit_x(1'b1, s);
		o_scl_low = 1'b0;
		#HALF;
		o_sda_low = 1'b1;
		#HALF;
		o_scl_low = 1'b1;
	endtask

	task automatic stop();
		logic s;
		o_sda_low = 1'b1;
		#HALF;
		o_scl_low = 1'b0;
		wait (i_scl === 1'b1);
		#HALF;
		o_sda_low = 1'b0;
		#HALF;
	endtask

	// Byte out MSB first, then sample the acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, s);
		ack = !s;
	endtask

	// a one in the ninth bit refuses more data
	// Ninth bit goes to a scratch bit so the data LSB survives
	task automatic rbyte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(nack, s);
	endtask
endmodule // mas_i2c_master
`default_nettype wire

// >>> tb/tb.sv
// Testbench: register-level tests of the multi-address I2C slave
`timescale 1ns/1ps
`default_nettype none

module tb
	import mas_pkg::*;
;
	logic         clk   = 1'b0;
	logic         rst   = 1'b1;
	logic [7:0]   addr  = 8'h00;
	logic [31:0]  wdata = 32'h0;
	logic         wr    = 1'b0;
	logic         rd    = 1'b0;
	logic         cdone = 1'b0;
	logic [47:0]  cavg  = {12'h4f0, 12'h3c3, 12'h2a5, 12'h13c};
	logic [31:0]  rdata;
	logic         done;
	logic         stop_seen;
	logic         scl_low;
	logic         sda_low;
	logic         ack;
	mas_pin_out_s pout;
	mas_pin_in_s  pin;
	int           errors    = 0;
	int           tests_run = 0;

	// Pulled-up open-drain lines: low while any party pulls
	assign pin = {!(scl_low || pout.scl_oe === 1'b1), !(sda_low || pout.sda_oe === 1'b1)};
	// Clock
	always #5 clk = !clk;

	mas_slave uut (.i_sys_clk(clk), .i_reset(rst), .i_pins(pin), .o_pins(pout),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.o_byte_done(done), .o_stop_seen(stop_seen), .i_conv_done(cdone), .i_conv_avg(cavg));
	mas_i2c_master m (.i_scl(pin.scl), .i_sda(pin.sda), .o_scl_low(scl_low), .o_sda_low(sda_low));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read answer stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk($sformatf("reg %h", a), e, rdata & mk);
	endtask

	// Bounded poll of the completion flag
	task automatic wait_done();
		for (int i = 0; i < 600 && done !== 1'b1; i++) @(negedge clk);
		chk("byte done", 1, done);
	endtask

	task automatic end_stop();
		m.stop();
		repeat (10) @(negedge clk);
		chk("stop set", 1, stop_seen);
		repeat (40) @(negedge clk);
		chk("stop kept", 1, stop_seen);
		wreg(MAS_REG_FLAGS, 32'h2);
		@(negedge clk);
		chk("stop cleared", 0, stop_seen);
	endtask

	// Write frame: address, then each byte serviced by software
	task automatic wtx(input logic [7:0] a, input logic [3:0] g, input logic [7:0] q[$]);
		m.start();
		m.wbyte(a, ack);
		chk("addr ack", 1, ack);
		foreach (q[i]) begin
			m.wbyte(q[i], ack);
			chk("data ack", 1, ack);
			wait_done();
			rchk(MAS_REG_RXHOLD, 32'hff, q[i]);
			rchk(MAS_REG_STATUS, 32'hf8, {g, 4'h0});
			// No-op action code must leave the stall in place
			wreg(MAS_REG_ACTION, 32'h0);
			@(negedge clk);
			chk("no-op keeps stall", 1, done);
			wreg(MAS_REG_ACTION, 32'h100);
		end
	endtask

	// Read frame: transmit action per byte, master refuses the last
	task automatic rdx(input logic [7:0] a, input logic [3:0] g, input logic [31:0] act,
		input logic [7:0] q[$]);
		logic [7:0] d;
		m.start();
		m.wbyte(a, ack);
		chk("addr ack", 1, ack);
		foreach (q[i]) begin
			wait_done();
			rchk(MAS_REG_STATUS, i ? 32'h0c : 32'hf8, i ? 32'h0c : {g, 4'h8});
			wreg(MAS_REG_ACTION, act);
			m.rbyte(i == q.size() - 1, d);
			chk("tx byte", q[i], d);
		end
		wait_done();
		rchk(MAS_REG_STATUS, 32'h04, 32'h0);
		wreg(MAS_REG_ACTION, 32'h300);
		rchk(MAS_REG_STATUS, 32'hff, 32'h0);
		end_stop();
	endtask

	task automatic probe(input logic [7:0] a, input logic e);
		m.start();
		m.wbyte(a, ack);
		chk("probe ack", e, ack);
		// Unselected: a following data byte must not be acknowledged
		if (!e) begin
			m.wbyte(8'h00, ack);
			chk("skip ack", 0, ack);
		end
		m.stop();
		wreg(MAS_REG_FLAGS, 32'h2);
	endtask

	// Watchdog on the whole run
	initial begin
		#500us;
		errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		rchk(MAS_REG_STATUS, 32'hff, MAS_STATUS_RST);
		rchk(MAS_REG_FLAGS, 32'h3, 32'h0);
		rchk(8'h1c, 32'hffffffff, 32'h0);
		@(posedge clk);
		cdone <= 1'b1;
		@(posedge clk);
		cdone <= 1'b0;
		wtx(8'h60, 4'h1, '{8'ha5, 8'h01});
		end_stop();
		rdx(8'h61, 4'h1, 32'ha00, '{8'h01, 8'h3c, 8'h02, 8'ha5, 8'h03, 8'hc3, 8'h04, 8'hf0,
			8'h01});
		wtx(8'h70, 4'h2, '{8'h7f, 8'haa, 8'h55});
		end_stop();
		wtx(8'h70, 4'h2, '{8'h7f});
		rdx(8'h71, 4'h2, 32'h600, '{8'haa, 8'h55});
		probe(8'h50, 1'b0);
		wreg(MAS_REG_ADRTBL, 32'h2810);
		probe(8'h50, 1'b1);
		wreg(MAS_REG_ACKTBL, 32'h300);
		probe(8'h80, 1'b0);
		probe(8'h90, 1'b1);
		// Transmit byte taken from the action's own data field
		rdx(8'h91, 4'h4, 32'h2c3, '{8'hc3});
		wrap_up();
	end
endmodule // tb
`default_nettype wire
